// file: design/gcs_gig_copper.sv
// Decided for this implementation: register access over AHB-Lite.
`include "gcs_consts.svh"
`default_nettype none
// overview of the block:
// two 16-bit management registers sit in the
// low half of 32-bit bus words; control at one
// word, status at the next one up.
// a small interrupt side bank is added on top:
// sticky status, a mask and an event register.
// the event register stands in for the core's
// own software reset and restart bits, which
// live in a register outside this block.
// everything is one packed state struct so a
// single comb process owns every next value.
// the core sees only the applied (live) copy of
// the master/slave and advertisement bits; the
// host only ever reads back the pending copy.
// status inputs are plain levels from the core,
// already in this clock domain.
// hazard: a host that polls status too often
// keeps the idle counter near zero; that is
// the intended clear-on-read behaviour.
module gcs_gig_copper (
    // clock and reset
    input  wire logic        MCLK_I,
    input  wire logic        NRST_I,
    // ahb-lite slave
    input  wire logic        HSEL_I,
    input  wire logic [7:0]  HADDR_I,
    input  wire logic [1:0]  HTRANS_I,
    input  wire logic        HWRITE_I,
    input  wire logic [2:0]  HSIZE_I,
    input  wire logic [31:0] HWDATA_I,
    input  wire logic        HREADY_I,
    output logic             HREADYOUT_O,
    output logic             HRESP_O,
    output logic [31:0]      HRDATA_O,
    // straps, sampled once after reset release
    input  wire logic        STRAP_MASTER_SLAVE_DEFAULT_I,
    input  wire logic        STRAP_GIG_HALF_DUPLEX_DEFAULT_I,
    // core status inputs
    input  wire logic        POWER_DOWN_I,
    input  wire logic        LINK_UP_I,
    input  wire logic        AN_COMPLETE_I,
    input  wire logic        MS_FAULT_I,
    input  wire logic        MS_RESOLVED_MASTER_I,
    input  wire logic        LOCAL_RX_OK_I,
    input  wire logic        REMOTE_RX_OK_I,
    input  wire logic        LP_GIG_FD_I,
    input  wire logic        LP_GIG_HD_I,
    input  wire logic        IDLE_ERR_I,
    // outputs to the gigabit core
    output logic [2:0]       TEST_MODE_O,
    output logic             TX_CLK_FROM_RX_O,
    output logic             MS_MANUAL_O,
    output logic             MS_MANUAL_MASTER_O,
    output logic             PREFER_MASTER_O,
    output logic             ADV_GIG_FD_O,
    output logic             ADV_GIG_HD_O,
    output logic             SW_RESET_O,
    output logic             AN_RESTART_O,
    // interrupt
    output logic             IRQ_O
);
    gcs_pkg::gcs_state_s r;      // registered state
    gcs_pkg::gcs_state_s next_r; // next state

    logic        addr_ok;     // address phase accepted
    logic        trigger;     // pending config applies now
    logic        rd_stat;     // status register read this cycle
    logic [15:0] ctrl_word;   // control readback
    logic [15:0] stat_word;   // status readback
    logic [31:0] rdata;       // selected read data
    logic [2:0]  irq_ev;      // interrupt events this cycle
    logic        idle_sat;    // counter just hit the top

    // the control word shows the pending copy,
    // so the host sees what it last wrote even
    // while the core still runs the old values.
    // the reserved byte is stored and echoed, it
    // has no effect on the core.
    // status bits 9:8 are hard zero.
    // the idle counter sits in the low byte.
    // readback words
    always_comb
    begin
        ctrl_word = {r.test_mode, r.pend.man_en, r.pend.man_val, r.pend.port_type,
                     r.pend.adv_fd, r.pend.adv_hd, r.rsvd};
        stat_word = {r.fault, r.resolved, r.local_ok, r.remote_ok,
                     r.lp_fd, r.lp_hd, 2'h0, r.idle_cnt};
    end

    // the mux is decoded from the live address so
    // that data can be registered at the address
    // edge; that keeps the slave wait-free.
    // trade-off: the status snapshot is taken one
    // cycle before the host actually samples it.
    // read mux, latched in the address phase so data is ready for the data phase
    always_comb
    begin
        case (HADDR_I)
            `GCS_ADDR_CTRL:     rdata = {16'h0000, ctrl_word};
            `GCS_ADDR_STAT:     rdata = {16'h0000, stat_word};
            `GCS_ADDR_IRQ_STAT: rdata = {29'h0, r.irq_stat};
            `GCS_ADDR_IRQ_MASK: rdata = {29'h0, r.irq_mask};
            default:            rdata = 32'h0000_0000; // unmapped reads zero
        endcase
    end

    // one process computes the whole next state.
    // the order of the blocks below matters: later
    // assignments win, so resets and set events
    // are placed after the plain bus writes.
    // pulse bits default to zero every cycle, so
    // an event register write lasts one cycle.
    // every helper signal except trigger gets a value up front.
    // next-state logic
    always_comb
    begin
        next_r = r;
        addr_ok = HSEL_I && HREADY_I && HTRANS_I[1];
        rd_stat = addr_ok && !HWRITE_I && (HADDR_I == `GCS_ADDR_STAT);
        next_r.sw_reset = 1'b0;
        next_r.an_restart = 1'b0;
        irq_ev = 3'h0;
        idle_sat = 1'b0;

        // straps cannot be loaded in the async reset
        // branch, since that branch takes constants
        // only; they are copied at the first edge.
        // a bus write cannot land in that very first
        // cycle, since the bus state resets to idle.
        // straps caught by a clocked process once after release
        if (!r.strap_done)
        begin
            next_r.strap_done = 1'b1;
            next_r.pend.man_val = STRAP_MASTER_SLAVE_DEFAULT_I;
            next_r.pend.port_type = STRAP_MASTER_SLAVE_DEFAULT_I;
            next_r.pend.adv_hd = STRAP_GIG_HALF_DUPLEX_DEFAULT_I;
            next_r.live.man_val = STRAP_MASTER_SLAVE_DEFAULT_I;
            next_r.live.port_type = STRAP_MASTER_SLAVE_DEFAULT_I;
            next_r.live.adv_hd = STRAP_GIG_HALF_DUPLEX_DEFAULT_I;
        end

        // writes use the address kept from the
        // address phase and the data now on the bus.
        // the test-mode field acts at once; the
        // master/slave and advertisement bits only
        // go to the pending copy.
        // data phase: one wait-free cycle, writes land here
        next_r.bus = gcs_pkg::GCS_BUS_IDLE;
        if (r.bus == gcs_pkg::GCS_BUS_WRITE)
        begin
            case (r.addr)
                `GCS_ADDR_CTRL:
                begin
                    next_r.test_mode = HWDATA_I[`GCS_CTL_TM_HI:`GCS_CTL_TM_LO];
                    // held pending until a trigger event
                    next_r.pend.man_en = HWDATA_I[`GCS_CTL_MAN_EN];
                    next_r.pend.man_val = HWDATA_I[`GCS_CTL_MAN_VAL];
                    next_r.pend.port_type = HWDATA_I[`GCS_CTL_PORT_TYPE];
                    next_r.pend.adv_fd = HWDATA_I[`GCS_CTL_ADV_FD];
                    next_r.pend.adv_hd = HWDATA_I[`GCS_CTL_ADV_HD];
                    next_r.rsvd = HWDATA_I[7:0];
                end
                `GCS_ADDR_IRQ_STAT:
                    next_r.irq_stat = r.irq_stat & ~HWDATA_I[2:0];
                `GCS_ADDR_IRQ_MASK:
                    next_r.irq_mask = HWDATA_I[2:0];
                `GCS_ADDR_EVENT:
                begin
                    next_r.sw_reset = HWDATA_I[`GCS_EV_SW_RESET];
                    next_r.an_restart = HWDATA_I[`GCS_EV_AN_RESTART];
                end
                default:
                    next_r.rsvd = r.rsvd; // unmapped writes ignored
            endcase
        end

        // read data is captured here and stands
        // until the next accepted address phase.
        // address phase
        if (addr_ok)
        begin
            next_r.addr = HADDR_I;
            next_r.bus = HWRITE_I ? gcs_pkg::GCS_BUS_WRITE : gcs_pkg::GCS_BUS_READ;
            next_r.hrdata = HWRITE_I ? 32'h0000_0000 : rdata;
        end

        // both pulses return the transmitter to
        // normal; the reserved byte survives them.
        // software reset and restart pulses drive the core
        if (r.sw_reset)
        begin
            next_r.test_mode = `GCS_TM_RESET; // reserved byte retained
        end
        if (r.an_restart)
        begin
            next_r.test_mode = `GCS_TM_RESET;
        end

        // a trigger copies the pending set into the
        // live set, which drives the core outputs.
        // power-down exit and link loss are seen as
        // falling edges of their level inputs; the
        // edge history starts at zero, so no false
        // trigger follows reset for those two.
        // pending settings take effect on any trigger
        trigger = r.sw_reset || r.an_restart || (r.pd_q && !POWER_DOWN_I)
                  || (r.link_q && !LINK_UP_I);
        if (trigger)
        begin
            next_r.live = next_r.pend;
            irq_ev[`GCS_IRQ_APPLY] = 1'b1;
        end
        next_r.pd_q = POWER_DOWN_I;
        next_r.link_q = LINK_UP_I;

        // receiver and page results are sampled
        // each cycle and shown one cycle later.
        // live receiver status
        next_r.local_ok = LOCAL_RX_OK_I;
        next_r.remote_ok = REMOTE_RX_OK_I;
        // page-exchange results only once negotiation is done
        next_r.resolved = AN_COMPLETE_I && MS_RESOLVED_MASTER_I;
        next_r.lp_fd = AN_COMPLETE_I && LP_GIG_FD_I;
        next_r.lp_hd = AN_COMPLETE_I && LP_GIG_HD_I;

        // a fault seen in the read cycle must not be
        // lost, so the set is placed after the clear.
        // fault latch: a new fault wins over the read clear
        if (rd_stat)
        begin
            next_r.fault = 1'b0;
        end
        if (MS_FAULT_I)
        begin
            next_r.fault = 1'b1;
            irq_ev[`GCS_IRQ_FAULT] = 1'b1;
        end

        // the counter stops at its top value rather
        // than wrapping, so a busy line never looks
        // clean; reaching the top raises an event.
        // idle-error counter; an error in the read cycle counts as one
        if (rd_stat)
        begin
            next_r.idle_cnt = {7'h00, IDLE_ERR_I};
        end
        else if (IDLE_ERR_I && r.idle_cnt != `GCS_IDLE_MAX)
        begin
            next_r.idle_cnt = r.idle_cnt + 8'h01;
            idle_sat = (r.idle_cnt == (`GCS_IDLE_MAX - 8'h01));
        end
        irq_ev[`GCS_IRQ_IDLE_SAT] = idle_sat;

        // events are or-ed in last, so a clear write
        // in the same cycle cannot hide a new event.
        // sticky interrupts, set beats clear
        next_r.irq_stat = next_r.irq_stat | irq_ev;
        next_r.irq = |(next_r.irq_stat & next_r.irq_mask);

        // jitter tests clock transmit from the receive pin
        next_r.tx_from_rx = (next_r.test_mode == gcs_pkg::GCS_TM_JIT_MST)
                            || (next_r.test_mode == gcs_pkg::GCS_TM_JIT_SLV);
    end

    // the whole struct resets to zero, except the
    // full-duplex advertisement, which starts set.
    // only constants appear in the reset branch.
    // state register; straps are loaded after release, not here
    always_ff @(posedge MCLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
        begin
            r <= '0;
            r.pend.adv_fd <= `GCS_ADV_FD_RESET;
            r.live.adv_fd <= `GCS_ADV_FD_RESET;
        end
        else
        begin
            r <= next_r;
        end
    end

    // every output is a register field or a
    // constant; no logic sits after the flops
    // apart from the manual gate on the port
    // preference, which only masks a flop.
    // outputs straight from flops
    assign HREADYOUT_O = 1'b1; // zero-wait slave
    assign HRESP_O = 1'b0;
    assign HRDATA_O = r.hrdata;
    assign TEST_MODE_O = r.test_mode;
    assign TX_CLK_FROM_RX_O = r.tx_from_rx;
    assign MS_MANUAL_O = r.live.man_en;
    assign MS_MANUAL_MASTER_O = r.live.man_val;
    // preference means nothing under manual configuration
    assign PREFER_MASTER_O = r.live.port_type & ~r.live.man_en;
    assign ADV_GIG_FD_O = r.live.adv_fd;
    assign ADV_GIG_HD_O = r.live.adv_hd;
    assign SW_RESET_O = r.sw_reset;
    assign AN_RESTART_O = r.an_restart;
    assign IRQ_O = r.irq;
endmodule
`default_nettype wire

// file: design/gcs_consts.svh
`ifndef GCS_CONSTS_SVH
`define GCS_CONSTS_SVH
// register byte addresses (printed index times four)
`define GCS_IDX_CTRL        4'h9
`define GCS_IDX_STAT        4'ha
`define GCS_ADDR_CTRL       8'h24
`define GCS_ADDR_STAT       8'h28
`define GCS_ADDR_IRQ_STAT   8'h40
`define GCS_ADDR_IRQ_MASK   8'h44
`define GCS_ADDR_EVENT      8'h48
// control field positions
`define GCS_CTL_TM_HI       15
`define GCS_CTL_TM_LO       13
`define GCS_CTL_MAN_EN      12
`define GCS_CTL_MAN_VAL     11
`define GCS_CTL_PORT_TYPE   10
`define GCS_CTL_ADV_FD      9
`define GCS_CTL_ADV_HD      8
// status field positions
`define GCS_ST_FAULT        15
`define GCS_ST_RESOLVED     14
`define GCS_ST_LOCAL_OK     13
`define GCS_ST_REMOTE_OK    12
`define GCS_ST_LP_FD        11
`define GCS_ST_LP_HD        10
// reset values and the idle counter top
`define GCS_TM_RESET        3'h0
`define GCS_MAN_EN_RESET    1'h0
`define GCS_ADV_FD_RESET    1'h1
`define GCS_RSVD_RESET      8'h00
`define GCS_IDLE_MAX        8'hff
// event-register bits (write one to pulse)
`define GCS_EV_SW_RESET     0
`define GCS_EV_AN_RESTART   1
// interrupt status bits
`define GCS_IRQ_FAULT       0
`define GCS_IRQ_IDLE_SAT    1
`define GCS_IRQ_APPLY       2
`define GCS_IRQ_W           3
`endif

// file: design/gcs_pkg.sv
`default_nettype none
package gcs_pkg;
    // transmit test modes; 101..111 reserved
    typedef enum logic [2:0] {
        GCS_TM_NORMAL  = 3'h0,
        GCS_TM_WAVE    = 3'h1,
        GCS_TM_JIT_MST = 3'h2,
        GCS_TM_JIT_SLV = 3'h3,
        GCS_TM_DIST    = 3'h4
    } gcs_tm_e;

    // bus data-phase state, gray along idle->write->read
    typedef enum logic [1:0] {
        GCS_BUS_IDLE  = 2'h0,
        GCS_BUS_WRITE = 2'h1,
        GCS_BUS_READ  = 2'h3
    } gcs_bus_e;

    // gigabit advertisement / master-slave settings
    typedef struct packed {
        logic man_en;
        logic man_val;
        logic port_type;
        logic adv_fd;
        logic adv_hd;
    } gcs_cfg_s;

    // whole state of the block
    typedef struct packed {
        gcs_bus_e   bus;
        logic [7:0] addr;
        logic [2:0] test_mode;
        gcs_cfg_s   pend;
        gcs_cfg_s   live;
        logic [7:0] rsvd;
        logic       fault;
        logic       resolved;
        logic       local_ok;
        logic       remote_ok;
        logic       lp_fd;
        logic       lp_hd;
        logic [7:0] idle_cnt;
        logic [2:0] irq_stat;
        logic [2:0] irq_mask;
        logic       strap_done;
        logic       pd_q;
        logic       link_q;
        logic       sw_reset;
        logic       an_restart;
        logic [31:0] hrdata;
        logic       irq;
        logic       tx_from_rx;
    } gcs_state_s;
endpackage
`default_nettype wire

// file: bench/gcs_gig_copper_monitor.sv
`include "gcs_consts.svh"
`default_nettype none
module gcs_gig_copper_chk (
    // clock, reset and bus
    input wire logic        MCLK_I,
    input wire logic        NRST_I,
    input wire logic        HSEL_I,
    input wire logic [7:0]  HADDR_I,
    input wire logic [1:0]  HTRANS_I,
    input wire logic        HWRITE_I,
    input wire logic [31:0] HRDATA_O,
    // core side
    input wire logic        POWER_DOWN_I,
    input wire logic        LINK_UP_I,
    input wire logic        AN_COMPLETE_I,
    input wire logic        MS_FAULT_I,
    input wire logic        LOCAL_RX_OK_I,
    input wire logic [2:0]  TEST_MODE_O,
    input wire logic        TX_CLK_FROM_RX_O,
    input wire logic        MS_MANUAL_O,
    input wire logic        MS_MANUAL_MASTER_O,
    input wire logic        PREFER_MASTER_O,
    input wire logic        ADV_GIG_FD_O,
    input wire logic        ADV_GIG_HD_O,
    input wire logic        SW_RESET_O,
    input wire logic        AN_RESTART_O
);
    default clocking cb @(posedge MCLK_I);
    endclocking
    default disable iff (!NRST_I);
    logic       rd_q; // status read answering now
    logic       pd_q; // last power-down level
    logic       lk_q; // last link level
    logic [2:0] up;   // settle count, straps land late
    wire logic [4:0] cfg = {MS_MANUAL_O, MS_MANUAL_MASTER_O, PREFER_MASTER_O, ADV_GIG_FD_O, ADV_GIG_HD_O};
    // any event allowed to move the applied settings
    wire logic trig = SW_RESET_O | AN_RESTART_O | (pd_q & ~POWER_DOWN_I) | (lk_q & ~LINK_UP_I);
    // helper history
    always_ff @(posedge MCLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
        begin
            rd_q <= 1'b0;
            pd_q <= 1'b0;
            lk_q <= 1'b0;
            up   <= 3'h0;
        end
        else
        begin
            rd_q <= HSEL_I & HTRANS_I[1] & ~HWRITE_I & (HADDR_I == `GCS_ADDR_STAT);
            pd_q <= POWER_DOWN_I;
            lk_q <= LINK_UP_I;
            up   <= up + {2'h0, up != 3'h7};
        end
    end
    a_txclk_jitter: assert property ($stable(TEST_MODE_O)
        |-> TX_CLK_FROM_RX_O == (TEST_MODE_O inside {3'h2, 3'h3}))
        else $error("tx clock source wrong");
    a_restart_clears: assert property (AN_RESTART_O |-> ##[0:1] TEST_MODE_O == 3'h0)
        else $error("test mode kept over restart");
    a_cfg_on_trigger: assert property ($changed(cfg) && up == 3'h7 |-> trig || $past(trig) || $past(trig, 2))
        else $error("settings moved without trigger");
    a_port_ignored: assert property (MS_MANUAL_O |-> !PREFER_MASTER_O)
        else $error("port preference used in manual");
    a_rsvd_zero: assert property (rd_q |-> HRDATA_O[9:8] == 2'h0)
        else $error("status 9:8 not zero");
    a_fault_latch: assert property (rd_q && $past(MS_FAULT_I, 2) |-> HRDATA_O[`GCS_ST_FAULT])
        else $error("fault not latched");
    a_local_shown: assert property (rd_q && $past(LOCAL_RX_OK_I, 2) == $past(LOCAL_RX_OK_I, 3)
        |-> HRDATA_O[`GCS_ST_LOCAL_OK] == $past(LOCAL_RX_OK_I, 2))
        else $error("local receiver status wrong");
    a_unneg_zero: assert property (rd_q && !$past(AN_COMPLETE_I) && !$past(AN_COMPLETE_I, 2)
        |-> HRDATA_O[14] == 1'b0 && HRDATA_O[11:10] == 2'h0)
        else $error("partner status before negotiation");
    c_fault_read: cover property (rd_q && HRDATA_O[15]);
    c_jitter: cover property (TX_CLK_FROM_RX_O);
    c_restart: cover property (AN_RESTART_O);
endmodule
bind gcs_gig_copper gcs_gig_copper_chk i_gcs_gig_copper_chk (.*);
`default_nettype wire

// file: bench/gcs_host_model.sv
`include "gcs_consts.svh"
`default_nettype none
module gcs_host_model (
    // clock and bus answer
    input  wire logic        clk_i,
    input  wire logic        hready_i,
    input  wire logic [31:0] hrdata_i,
    // bus request
    output logic [7:0]       haddr_o = 8'h00,
    output logic [1:0]       htrans_o = 2'h0,
    output logic             hwrite_o = 1'b0,
    output logic [31:0]      hwdata_o = 32'h0
);
    timeunit 1ns;
    timeprecision 1ps;
    logic hung = 1'b0; // slave never answered
    // one single word transfer, address then data phase
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        @(posedge clk_i);
        haddr_o  <= a;
        htrans_o <= 2'h2;
        hwrite_o <= w;
        for (int p = 0; p < 2; p++)
        begin
            n = 0;
            do
            begin
                @(posedge clk_i);
                n++;
            end
            while (hready_i !== 1'b1 && n < 64);
            hung     = hung | (hready_i !== 1'b1);
            htrans_o <= 2'h0;
            // reserved control bits always written as zero
            hwdata_o <= (w && a == `GCS_ADDR_CTRL) ? {d[31:8], 8'h00} : d;
        end
        q = hrdata_i;
    endtask
endmodule
`default_nettype wire

// file: bench/test_gcs_gig_copper.sv
`include "gcs_consts.svh"
`default_nettype none
module test_gcs_gig_copper;
    timeunit 1ns;
    timeprecision 1ps;
    // design outputs
    logic        HREADYOUT_O, HRESP_O, TX_CLK_FROM_RX_O, MS_MANUAL_O, MS_MANUAL_MASTER_O, IRQ_O;
    logic        PREFER_MASTER_O, ADV_GIG_FD_O, ADV_GIG_HD_O, SW_RESET_O, AN_RESTART_O;
    logic [31:0] HRDATA_O;
    logic [2:0]  TEST_MODE_O;
    // clock, reset, bus
    logic        MCLK_I = 1'b0;
    logic        NRST_I = 1'b0;
    logic [7:0]  HADDR_I;
    logic [1:0]  HTRANS_I;
    logic        HWRITE_I;
    logic [31:0] HWDATA_I;
    wire logic   HREADY_I = HREADYOUT_O;
    wire logic   HSEL_I = 1'b1;        // lone slave
    wire logic [2:0] HSIZE_I = 3'h2;   // words only
    wire logic   STRAP_MASTER_SLAVE_DEFAULT_I = 1'b1;
    wire logic   STRAP_GIG_HALF_DUPLEX_DEFAULT_I = 1'b0;
    // core levels
    logic        POWER_DOWN_I = 1'b0;
    logic        LINK_UP_I = 1'b1;
    logic        AN_COMPLETE_I = 1'b0;
    logic        MS_FAULT_I = 1'b0;
    logic        MS_RESOLVED_MASTER_I = 1'b0;
    logic        LOCAL_RX_OK_I = 1'b0;
    logic        REMOTE_RX_OK_I = 1'b0;
    logic        LP_GIG_FD_I = 1'b0;
    logic        LP_GIG_HD_I = 1'b0;
    logic        IDLE_ERR_I = 1'b0;
    int          checked = 0;
    int          miscompares = 0;
    logic        irq_seen;
    logic [15:0] cur;
    logic [15:0] nxt [3] = '{16'h1100, 16'h0600, 16'h1f00};
    wire logic [4:0] cfg = {MS_MANUAL_O, MS_MANUAL_MASTER_O, PREFER_MASTER_O, ADV_GIG_FD_O, ADV_GIG_HD_O};
    gcs_gig_copper i_gcs_gig_copper (.*);
    gcs_host_model i_gcs_host_model (.clk_i(MCLK_I), .hready_i(HREADY_I), .hrdata_i(HRDATA_O),
        .haddr_o(HADDR_I), .htrans_o(HTRANS_I), .hwrite_o(HWRITE_I), .hwdata_o(HWDATA_I));
    initial
        forever #20 MCLK_I = ~MCLK_I;
    // expected core outputs for a control word
    function automatic logic [4:0] cfg_of(input logic [15:0] v);
        return {v[12], v[11], v[10] & ~v[12], v[9], v[8]};
    endfunction
    task automatic complete_run();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e)
        begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask
    // a hung bus ends the run at once
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        i_gcs_host_model.xfer(w, a, d, q);
        if (i_gcs_host_model.hung)
        begin
            miscompares++;
            complete_run();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
        logic [31:0] q;
        xfer(1'b0, a, 32'h0, q);
        chk(n, e, q);
    endtask
    task automatic clk(input int n);
        repeat (n) @(posedge MCLK_I);
    endtask
    // 0 link loss, 1 power-down exit, 2 software reset
    task automatic trig(input int k);
        if (k == 0)
            LINK_UP_I <= 1'b0;
        else if (k == 1)
            POWER_DOWN_I <= 1'b1;
        else
            wr(`GCS_ADDR_EVENT, 32'h1);
        clk(2);
        LINK_UP_I <= 1'b1;
        POWER_DOWN_I <= 1'b0;
    endtask
    initial
    begin
        clk(4);
        NRST_I <= 1'b1;
        clk(3);
        chk("response", 32'h0, {31'h0, HRESP_O});
        rd(`GCS_ADDR_CTRL, 32'h0e00, "control reset");
        chk("applied reset", {27'h0, cfg_of(16'h0e00)}, {27'h0, cfg});
        rd(`GCS_ADDR_STAT, 32'h0, "status reset");
        for (int m = 0; m < 5; m++)
        begin
            wr(`GCS_ADDR_CTRL, {16'h0, m[2:0], 13'h0e00});
            clk(2);
            chk("test mode", m, {29'h0, TEST_MODE_O});
            chk("tx clock", (m == 2 || m == 3), {31'h0, TX_CLK_FROM_RX_O});
        end
        wr(`GCS_ADDR_EVENT, 32'h2);
        rd(`GCS_ADDR_CTRL, 32'h0e00, "after restart");
        cur = 16'h0e00;
        for (int k = 0; k < 3; k++)
        begin
            wr(`GCS_ADDR_CTRL, {16'h0, nxt[k]});
            rd(`GCS_ADDR_CTRL, {16'h0, nxt[k]}, "pending");
            chk("held", {27'h0, cfg_of(cur)}, {27'h0, cfg});
            trig(k);
            clk(3);
            chk("applied", {27'h0, cfg_of(nxt[k])}, {27'h0, cfg});
            cur = nxt[k];
        end
        AN_COMPLETE_I <= 1'b1;
        MS_RESOLVED_MASTER_I <= 1'b1;
        LOCAL_RX_OK_I <= 1'b1;
        LP_GIG_FD_I <= 1'b1;
        MS_FAULT_I <= 1'b1;
        IDLE_ERR_I <= 1'b1;
        clk(5);
        IDLE_ERR_I <= 1'b0;
        rd(`GCS_ADDR_STAT, 32'he805, "status");
        MS_FAULT_I <= 1'b0;
        rd(`GCS_ADDR_STAT, 32'he800, "fault latched");
        rd(`GCS_ADDR_STAT, 32'h6800, "fault cleared");
        IDLE_ERR_I <= 1'b1;
        clk(300);
        IDLE_ERR_I <= 1'b0;
        rd(`GCS_ADDR_STAT, 32'h68ff, "saturated");
        AN_COMPLETE_I <= 1'b0;
        REMOTE_RX_OK_I <= 1'b1;
        clk(2);
        rd(`GCS_ADDR_STAT, 32'h3000, "not negotiated");
        rd(`GCS_ADDR_IRQ_STAT, 32'h7, "irq status");
        wr(`GCS_ADDR_IRQ_MASK, 32'h0);
        clk(2);
        irq_seen = IRQ_O;
        wr(`GCS_ADDR_IRQ_MASK, 32'h7);
        rd(`GCS_ADDR_IRQ_MASK, 32'h7, "irq mask");
        chk("irq masking", {31'h0, ~irq_seen}, {31'h0, IRQ_O});
        wr(`GCS_ADDR_IRQ_STAT, 32'h7);
        rd(`GCS_ADDR_IRQ_STAT, 32'h0, "irq cleared");
        chk("irq idle", 32'h0, {31'h0, IRQ_O});
        wr(8'h30, 32'hffffffff);
        rd(8'h30, 32'h0, "unmapped");
        complete_run();
    end
endmodule
`default_nettype wire
